/* hw/grs_map.vh */
`ifndef GRS_MAP_VH
`define GRS_MAP_VH
// reset hold time in microseconds; the longest hold, 7 ms
`define GRS_RESET_HOLD_US      7000
// clock rate in MHz
`define GRS_CLK_MHZ            10
// longest time rounds down
`define GRS_RESET_HOLD_CYC     (`GRS_RESET_HOLD_US * `GRS_CLK_MHZ)
// minimum external reset pulse in ns
`define GRS_MIN_PULSE_NS       300
// clock period in ns
`define GRS_CLK_PERIOD_NS      100
// least time rounds up
`define GRS_MIN_PULSE_CYC      ((`GRS_MIN_PULSE_NS + `GRS_CLK_PERIOD_NS - 1) / `GRS_CLK_PERIOD_NS)
// boost enable bit position within extra_features_reg
`define GRS_BOOST_BIT          1
// extra_features_reg width and reset value
`define GRS_XF_WIDTH           8
`define GRS_XF_RESET           8'h00
`endif

/* hw/grs_sync.v */
`timescale 1ns/1ps
// two-stage synchroniser for a pin level; reset value is a parameter constant
module grs_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_async,
  output wire o_sync
);
  reg meta_reg;
  reg sync_reg;

  // first stage read only by second stage
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule // grs_sync

/* hw/grs_reset_seq.v */
`timescale 1ns/1ps
`include "grs_map.vh"
module grs_reset_seq #(
  parameter HOLD_CYC = `GRS_RESET_HOLD_CYC
) (
  // clock and reset
  input  wire                     i_clk,
  input  wire                     i_rst_n,
  // supply monitor levels from analog comparators
  input  wire                     i_main_supply_ok,
  input  wire                     i_bank_a_supply_low,
  input  wire                     i_bank_b_supply_low,
  // active-low reset pin, open drain
  input  wire                     i_active_low_reset_pin,
  output wire                     o_active_low_reset_pin,
  output wire                     o_active_low_reset_pin_oe,
  // extra_features_reg write port from the serial front end
  input  wire                     i_xf_wr,
  input  wire [`GRS_XF_WIDTH-1:0] i_xf_wdata,
  output reg  [`GRS_XF_WIDTH-1:0] o_xf_rdata,
  // status towards the rest of the chip
  output wire                     o_core_rst_n,
  output wire                     o_access_en,
  output reg                      o_boost_en,
  output reg                      o_ext_reset_seen
);

  ////////////////////////////////////////////////////////////////////////////
  // states
  localparam [1:0] ST_OFF  = 2'b00;
  localparam [1:0] ST_HOLD = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam [1:0] ST_RUN  = 2'b11;
  // minimum outside pulse in cycles, used only to flag a proper reset
  localparam [31:0] PULSE_CYC = `GRS_MIN_PULSE_CYC;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] cnt_reg;
  reg  [31:0] cnt_next;
  reg  [31:0] low_cnt_reg;
  reg         oe_reg;
  reg         run_reg;
  wire        pin_s;
  wire        sup_s;
  wire        bank_a_s;
  wire        bank_b_s;

  ////////////////////////////////////////////////////////////////////////////
  // state decodes shared by the pin driver, the gating and the flags;
  // one place to change if the state codes ever move
  function pulls_pin;
    input [1:0] st;
    begin
      pulls_pin = (st == ST_OFF) || (st == ST_HOLD);
    end
  endfunction

  // only the run state lets the core out of reset and opens access
  function is_run;
    input [1:0] st;
    begin
      is_run = (st == ST_RUN);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronise all pins and analog levels
  // a low shorter than one clock may be missed; hosts keep the minimum pulse
  grs_sync #(.RST_VAL(1'b0)) u_sync_pin (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_active_low_reset_pin),
    .o_sync  (pin_s)
  );
  grs_sync #(.RST_VAL(1'b0)) u_sync_sup (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_main_supply_ok),
    .o_sync  (sup_s)
  );
  grs_sync #(.RST_VAL(1'b0)) u_sync_ba (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_bank_a_supply_low),
    .o_sync  (bank_a_s)
  );
  grs_sync #(.RST_VAL(1'b0)) u_sync_bb (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_bank_b_supply_low),
    .o_sync  (bank_b_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: off until supply good, hold pin low, then wait for rise
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_OFF: begin
        // supply loss from any state comes straight back here
        cnt_next  = 32'h0000_0000;
        if (sup_s) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // counts whole cycles from zero, so the pin stays pulled HOLD_CYC cycles
        cnt_next  = cnt_reg + 32'h0000_0001;
        if (!sup_s) begin
          state_next = ST_OFF;
        end else if (cnt_reg >= HOLD_CYC - 1) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // pin released; pull-up may be slow, so wait for the sampled high
        if (!sup_s) begin
          state_next = ST_OFF;
        end else if (pin_s) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // any low seen on the pin re-enters wait until it rises
        if (!sup_s) begin
          state_next = ST_OFF;
        end else if (!pin_s) begin
          state_next = ST_WAIT;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_OFF;
      cnt_reg   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin enable and core release
  // both come from flops loaded with the decode of the next state: a
  // two-bit state step (hold to wait) could otherwise glitch the core reset
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_reg  <= 1'b1;
      run_reg <= 1'b0;
    end else begin
      oe_reg  <= pulls_pin(state_next);
      run_reg <= is_run(state_next);
    end
  end

  // open drain: only ever drive zero, never high
  assign o_active_low_reset_pin    = 1'b0;
  assign o_active_low_reset_pin_oe = oe_reg;

  // core reset and access gating share one flop so they never disagree
  assign o_core_rst_n = run_reg;
  assign o_access_en  = run_reg;

  // flags an external low that met the minimum pulse; cleared at next startup
  // the count only starts from a low seen in run, so the release after
  // power-up is never taken for an outside reset
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_reg      <= 32'h0000_0000;
      o_ext_reset_seen <= 1'b0;
    end else if (is_run(state_reg) && !pin_s) begin
      low_cnt_reg <= 32'h0000_0001;
    end else if (state_reg == ST_WAIT && !pin_s && low_cnt_reg != 32'h0000_0000) begin
      if (low_cnt_reg + 32'h0000_0001 >= PULSE_CYC) begin
        o_ext_reset_seen <= 1'b1;
      end
      low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
    end else if (pulls_pin(state_reg)) begin
      low_cnt_reg      <= 32'h0000_0000;
      o_ext_reset_seen <= 1'b0;
    end else if (is_run(state_reg)) begin
      low_cnt_reg <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // extra_features_reg: defaults whenever the pin holds the chip in reset
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xf_rdata <= `GRS_XF_RESET;
    end else if (!is_run(state_reg)) begin
      // writes outside run are dropped, never queued
      o_xf_rdata <= `GRS_XF_RESET;
    end else if (i_xf_wr) begin
      o_xf_rdata <= i_xf_wdata;
    end
  end

  // boost only matters while a bank supply sits below the threshold
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_boost_en <= 1'b0;
    end else begin
      o_boost_en <= o_xf_rdata[`GRS_BOOST_BIT]
                    & (bank_a_s | bank_b_s);
    end
  end

endmodule // grs_reset_seq

/* testbench/grs_reset_seq_chk.sv */
`timescale 1ns/1ps
module grs_reset_seq_chk #(parameter HOLD_CYC = 20) (
  input wire       i_clk, i_rst_n, i_main_supply_ok, i_bank_a_supply_low,
  input wire       i_bank_b_supply_low, i_active_low_reset_pin, o_active_low_reset_pin,
  input wire       o_active_low_reset_pin_oe, o_core_rst_n, o_access_en, o_boost_en,
  input wire [7:0] o_xf_rdata
);
  int cnt;
  // cycles the pin has been pulled with supply good; restarts on supply loss
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) cnt <= 0;
    else cnt <= (o_active_low_reset_pin_oe && i_main_supply_ok) ? cnt + 1 : 0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  drive_low_a: assert property (!o_active_low_reset_pin)
    else $error("pin data not low");
  loss_off_a: assert property (!i_main_supply_ok [*3] |=> o_active_low_reset_pin_oe)
    else $error("pin not pulled after supply loss");
  hold_min_a: assert property ($fell(o_active_low_reset_pin_oe) |-> cnt >= HOLD_CYC)
    else $error("pin released early");
  hold_max_a: assert property (cnt <= HOLD_CYC + 5)
    else $error("pin held too long");
  pin_low_a: assert property (!i_active_low_reset_pin [*3] |=> !o_access_en)
    else $error("access while pin low");
  pin_rise_a: assert property ($rose(i_active_low_reset_pin) ##0
    (i_active_low_reset_pin && i_main_supply_ok) [*4] |=> o_access_en)
    else $error("no access after pin rise");
  boost_off_a: assert property ((!i_bank_a_supply_low && !i_bank_b_supply_low) [*4]
    |-> !o_boost_en) else $error("boost with banks high");
  xf_dflt_a: assert property (!o_core_rst_n [*2] |-> o_xf_rdata == 8'h00)
    else $error("register not default in reset");
  core_held_a: assert property (o_active_low_reset_pin_oe |-> !o_core_rst_n)
    else $error("core out of reset while pin pulled");
endmodule // grs_reset_seq_chk
bind grs_reset_seq grs_reset_seq_chk #(.HOLD_CYC(HOLD_CYC)) grs_reset_seq_chk_inst (.*);

/* testbench/grs_host_model.sv */
`timescale 1ns/1ps
// outside reset source; pull-up raises the pin when nobody pulls it
module grs_host_model (
  input  wire       i_clk,
  input  wire       i_dev_oe,
  input  wire       i_go,
  input  wire [7:0] i_len,
  output wire       o_pin
);
  reg [7:0] left_reg = 8'h00;
  // low pulse of i_len cycles; t_short drives one shorter than the minimum pulse
  always @(posedge i_clk)
    if (i_go) left_reg <= i_len;
    else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
  assign o_pin = !(i_dev_oe || (left_reg != 8'h00));
endmodule // grs_host_model

/* testbench/grs_reset_seq_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module grs_reset_seq_tb;
  reg clk = 0, rst_n = 0, sup = 0, ba = 0, bb = 0, wr = 0, go = 0;
  reg [7:0] wd = 8'h00, len = 8'h08;
  wire pin, oe, o0, core, acc, bst, ext;
  wire [7:0] rd;
  int failures = 0, tests_run = 0, n;
  always #50 clk = ~clk;
  grs_host_model grs_host_model_inst (.i_clk(clk), .i_dev_oe(oe), .i_go(go),
    .i_len(len), .o_pin(pin));
  grs_reset_seq #(.HOLD_CYC(20)) grs_reset_seq_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_main_supply_ok(sup), .i_bank_a_supply_low(ba), .i_bank_b_supply_low(bb),
    .i_active_low_reset_pin(pin), .o_active_low_reset_pin(o0),
    .o_active_low_reset_pin_oe(oe), .i_xf_wr(wr), .i_xf_wdata(wd), .o_xf_rdata(rd),
    .o_core_rst_n(core), .o_access_en(acc), .o_boost_en(bst), .o_ext_reset_seen(ext));
  task cyc(input int k); repeat (k) @(posedge clk); #1; endtask
  task wait_acc; n = 0; while (acc !== 1'b1 && n < 200) begin cyc(1); n++; end endtask
  task wr_reg(input [7:0] v);
    @(posedge clk) begin wr <= 1'b1; wd <= v; end
    @(posedge clk) wr <= 1'b0;
    cyc(1);
  endtask
  task t_power;
    @(posedge clk) sup <= 1'b1;
    #1;
    n = 0;
    while (oe === 1'b1 && n < 100) begin cyc(1); n++; end
    `CHK("hold_len", 1'b1, n >= 20 && n <= 24)
    `CHK("acc_early", 1'b0, acc)
    wait_acc;
    `CHK("acc_up", 1'b1, acc)
    `CHK("rd_dflt", 8'h00, rd)
    `CHK("pin_data", 1'b0, o0)
    `CHK("core_up", 1'b1, core)
    $display("test power done");
  endtask
  task t_boost;
    wr_reg(8'h02);
    `CHK("rd_wr", 8'h02, rd)
    cyc(4);
    `CHK("bst_high", 1'b0, bst)
    @(posedge clk) ba <= 1'b1;
    cyc(5);
    `CHK("bst_a", 1'b1, bst)
    @(posedge clk) begin ba <= 1'b0; bb <= 1'b1; end
    cyc(5);
    `CHK("bst_b", 1'b1, bst)
    wr_reg(8'hFD);
    cyc(4);
    `CHK("bst_clr", 1'b0, bst)
    $display("test boost done");
  endtask
  task t_ext;
    wr_reg(8'h02);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    cyc(3);
    `CHK("ext_acc", 1'b0, acc)
    `CHK("ext_core", 1'b0, core)
    wr_reg(8'h02);
    `CHK("ext_ign", 8'h00, rd)
    wait_acc;
    `CHK("ext_seen", 1'b1, ext)
    `CHK("ext_rd", 8'h00, rd)
    $display("test ext done");
  endtask
  task t_supply;
    @(posedge clk) sup <= 1'b0;
    cyc(4);
    `CHK("loss_oe", 1'b1, oe)
    `CHK("loss_acc", 1'b0, acc)
    `CHK("loss_ext", 1'b0, ext)
    t_power;
    $display("test supply done");
  endtask
  // a low shorter than the minimum pulse still resets but is not flagged
  task t_short;
    @(posedge clk) len <= 8'h02;
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    cyc(3);
    `CHK("short_acc", 1'b0, acc)
    wait_acc;
    `CHK("short_up", 1'b1, acc)
    `CHK("short_seen", 1'b0, ext)
    $display("test short done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_power;
    t_boost;
    t_ext;
    t_supply;
    t_short;
    tally_and_finish;
  end
  // tests need about 125 cycles; stop a hang well beyond that
  initial begin #200000; failures++; tally_and_finish; end
endmodule // grs_reset_seq_tb
